//--- pkg/psf_regs.vh
// Purpose: register map, field positions, codes and reset values of the
//          single-edge pwm channel
// Assumes: 8-bit byte address, one 32-bit word per register
// Notes:   definitions only
`ifndef PSF_REGS_VH
`define PSF_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PSF_ADDR_CTRL     8'h00
`define PSF_ADDR_OLC      8'h04
`define PSF_ADDR_PERIOD   8'h08
`define PSF_ADDR_DUTY     8'h0c
`define PSF_ADDR_BUFFER   8'h10
`define PSF_ADDR_COUNT    8'h14
`define PSF_ADDR_STATUS   8'h18
`define PSF_ADDR_MASK     8'h1c
`define PSF_ADDR_PINMODE  8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSF_CTRL_RUN      0
`define PSF_CTRL_BUF      1
`define PSF_CTRL_INIT     2
`define PSF_CTRL_DIV_LO   4
`define PSF_CTRL_DIV_HI   5
`define PSF_SEL_DUTY_LO   0
`define PSF_SEL_DUTY_HI   3
`define PSF_SEL_PER_LO    4
`define PSF_SEL_PER_HI    7
`define PSF_PIN_PWM       0
`define PSF_ST_PER        0
`define PSF_ST_DUTY       1

// ----------------------------------------------------------------
// output selector codes
// ----------------------------------------------------------------
`define PSF_ACT_LOW_A     4'h1
`define PSF_ACT_HIGH_A    4'h2
`define PSF_ACT_TOG_A     4'h3
`define PSF_ACT_LOW_B     4'h5
`define PSF_ACT_HIGH_B    4'h6
`define PSF_ACT_TOG_B     4'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSF_RST_CTRL      8'h00
`define PSF_RST_OLC       8'h00
`define PSF_RST_PERIOD    16'hffff
`define PSF_RST_DUTY      16'hffff
`define PSF_RST_BUFFER    16'hffff
`define PSF_RST_COUNT     16'h0000
`define PSF_RST_STATUS    2'h0
`define PSF_RST_MASK      2'h0

// ----------------------------------------------------------------
// timing: prescaler width, divide by 1, 2, 4 or 8
// ----------------------------------------------------------------
`define PSF_PRE_W         3

`endif

//--- core/psf_action.v
// Purpose: decode one output selector into a pin action at a match
// Assumes: pure combinational, caller gates with the match
// Notes:   undefined codes leave the level alone
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module psf_action
(
  input  wire [3:0] i_code,
  input  wire       i_level,
  output reg        o_change,
  output reg        o_level
);

  always @*
  begin
    o_change = 1'b1;
    o_level  = i_level;
    // [RQ2] low, high, toggle codes
    case (i_code)
      `PSF_ACT_LOW_A,
      `PSF_ACT_LOW_B:  o_level = 1'b0;
      `PSF_ACT_HIGH_A,
      `PSF_ACT_HIGH_B: o_level = 1'b1;
      `PSF_ACT_TOG_A,
      `PSF_ACT_TOG_B:  o_level = ~i_level;
      // [RQ19] other codes hold
      default:         o_change = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

//--- core/psf_irq.v
// Purpose: sticky event status, mask and level interrupt
// Assumes: write one to clear, event set wins over clear
// Notes:   interrupt output is registered
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module psf_irq
(
  input  wire       i_clk_sys,
  input  wire       i_sys_rst,
  input  wire [1:0] i_set,
  input  wire       i_clr_we,
  input  wire [1:0] i_clr_data,
  input  wire       i_mask_we,
  input  wire [1:0] i_mask_data,
  output reg  [1:0] o_status,
  output reg  [1:0] o_mask,
  output reg        o_irq
);

  reg  [1:0] status_d;
  reg  [1:0] mask_d;

  always @*
  begin
    status_d = o_status;
    if (i_clr_we)
    begin
      status_d = status_d & ~i_clr_data;
    end
    status_d = status_d | i_set;
    mask_d   = i_mask_we ? i_mask_data : o_mask;
  end

  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_status <= `PSF_RST_STATUS;
      o_mask   <= `PSF_RST_MASK;
      o_irq    <= 1'b0;
    end
    else
    begin
      o_status <= status_d;
      o_mask   <= mask_d;
      // [RQ12] period match interrupt
      o_irq    <= |(status_d & mask_d);
    end
  end

endmodule
`default_nettype wire

//--- core/psf_top.v
// Purpose: one timer channel in single-edge pwm mode with full range duty
// Assumes: 25 MHz system clock, registers on a plain strobe port
// Notes:   counter advances on prescaled ticks; read data one cycle later
//
// How it works
// [RQ1] period match clears the counter
// [RQ2] period selector 5h low, 6h high
// [RQ3] duty above period never matches
// [RQ4] buffer copied to duty on duty match
// [RQ5] duty zero matches at count 0 to 1
// [RQ6] duty zero with buffer loads at clear
// [RQ7] buffered over-period write reaches 0% later
// [RQ8] unbuffered over-period write: 0% next period
// [RQ9] duty selector 2h drives high
// [RQ10] duty selector 5h drives low
// [RQ11] software swaps period selector for 0 to 100
// [RQ12] interrupt on every period match
// [RQ13] pin starts initial level at mode write
// [RQ14] selectors rewritable while counting
// [RQ15] toggle at period match alternates 0/100
// [RQ16] software may switch duty selector to 2h
// [RQ17] reference: 40MHz, 1ms, period 9C3Fh
// [RQ18] coincident matches keep pin level
// [RQ19] undefined selector codes hold level
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module psf_top
(
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wr_data,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  output reg  [31:0] o_rd_data,
  output reg         o_pwm_output_pin,
  output reg         o_pwm_oe_n,
  output wire        o_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]           ctrl_q;
  reg  [7:0]           ctrl_d;
  reg  [7:0]           olc_q;
  reg  [7:0]           olc_d;
  reg  [15:0]          period_compare_reg_q;
  reg  [15:0]          period_compare_reg_d;
  reg  [15:0]          duty_compare_reg_q;
  reg  [15:0]          duty_compare_reg_d;
  reg  [15:0]          duty_buffer_reg_q;
  reg  [15:0]          duty_buffer_reg_d;
  reg  [15:0]          up_counter_q;
  reg  [15:0]          up_counter_d;
  reg  [`PSF_PRE_W-1:0] pre_q;
  reg  [`PSF_PRE_W-1:0] pre_d;
  reg                  pwm_mode_q;
  reg                  pwm_mode_d;
  reg                  pin_d;
  reg  [31:0]          rd_d;

  wire [1:0]           status;
  wire [1:0]           mask;
  wire                 duty_chg;
  wire                 duty_lvl;
  wire                 per_chg;
  wire                 per_lvl;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire we_ctrl   = i_wr_en && (i_addr == `PSF_ADDR_CTRL);
  wire we_olc    = i_wr_en && (i_addr == `PSF_ADDR_OLC);
  wire we_period = i_wr_en && (i_addr == `PSF_ADDR_PERIOD);
  wire we_duty   = i_wr_en && (i_addr == `PSF_ADDR_DUTY);
  wire we_buffer = i_wr_en && (i_addr == `PSF_ADDR_BUFFER);
  wire we_count  = i_wr_en && (i_addr == `PSF_ADDR_COUNT);
  wire we_status = i_wr_en && (i_addr == `PSF_ADDR_STATUS);
  wire we_mask   = i_wr_en && (i_addr == `PSF_ADDR_MASK);
  wire we_pin    = i_wr_en && (i_addr == `PSF_ADDR_PINMODE);

  wire       run_en  = ctrl_q[`PSF_CTRL_RUN];
  wire       buf_en  = ctrl_q[`PSF_CTRL_BUF];
  wire       init_lv = ctrl_q[`PSF_CTRL_INIT];
  wire [1:0] div_sel = ctrl_q[`PSF_CTRL_DIV_HI:`PSF_CTRL_DIV_LO];
  wire [3:0] duty_match_selector =
             olc_q[`PSF_SEL_DUTY_HI:`PSF_SEL_DUTY_LO];
  wire [3:0] period_match_selector =
             olc_q[`PSF_SEL_PER_HI:`PSF_SEL_PER_LO];

  // ----------------------------------------------------------------
  // prescaler and compare matches
  // ----------------------------------------------------------------
  // mask of prescaler bits that must all be one for a tick
  wire [`PSF_PRE_W-1:0] pre_mask =
    {(div_sel > 2'd2), (div_sel > 2'd1), (div_sel > 2'd0)};
  wire counting = run_en && pwm_mode_q;
  wire tick     = counting && ((pre_q & pre_mask) == pre_mask);

  // match takes effect as the counter leaves the compare value
  // [RQ5] zero matches on 0 to 1
  wire duty_hit   = tick && (up_counter_q == duty_compare_reg_q);
  // [RQ3] counter clears before reaching larger duty
  wire period_hit = tick && (up_counter_q == period_compare_reg_q);

  always @*
  begin
    pre_d = pre_q;
    if (!counting)
    begin
      pre_d = {`PSF_PRE_W{1'b0}};
    end
    else if (tick)
    begin
      pre_d = {`PSF_PRE_W{1'b0}};
    end
    else
    begin
      pre_d = pre_q + {{(`PSF_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always @*
  begin
    up_counter_d = up_counter_q;
    if (we_count)
    begin
      up_counter_d = i_wr_data[15:0];
    end
    // [RQ1] clear on period match
    else if (period_hit)
    begin
      up_counter_d = 16'h0000;
    end
    else if (tick)
    begin
      up_counter_d = up_counter_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // compare and buffer registers
  // ----------------------------------------------------------------
  always @*
  begin
    period_compare_reg_d = we_period ? i_wr_data[15:0]
                                     : period_compare_reg_q;
    duty_buffer_reg_d    = we_buffer ? i_wr_data[15:0]
                                     : duty_buffer_reg_q;
    duty_compare_reg_d   = duty_compare_reg_q;
    // [RQ8] direct write governs next match
    if (we_duty)
    begin
      duty_compare_reg_d = i_wr_data[15:0];
    end
    // [RQ4] transfer on duty match
    else if (buf_en && duty_hit)
    begin
      duty_compare_reg_d = duty_buffer_reg_q;
    end
    // [RQ6] zero duty loads at clear
    else if (buf_en && period_hit && (duty_compare_reg_q == 16'h0000))
    begin
      duty_compare_reg_d = duty_buffer_reg_q;
    end
  end
  // [RQ7] coincident match copies over-period value, next period low

  // ----------------------------------------------------------------
  // control, selectors and pin mode
  // ----------------------------------------------------------------
  always @*
  begin
    ctrl_d     = we_ctrl ? i_wr_data[7:0] : ctrl_q;
    // [RQ14] selectors writable while counting
    olc_d      = we_olc ? i_wr_data[7:0] : olc_q;
    pwm_mode_d = we_pin ? i_wr_data[`PSF_PIN_PWM] : pwm_mode_q;
  end

  // ----------------------------------------------------------------
  // output actions
  // ----------------------------------------------------------------
  // [RQ9] duty selector action
  psf_action u_duty_act
  (
    .i_code   (duty_match_selector),
    .i_level  (o_pwm_output_pin),
    .o_change (duty_chg),
    .o_level  (duty_lvl)
  );

  // [RQ2] period selector action
  psf_action u_per_act
  (
    .i_code   (period_match_selector),
    .i_level  (o_pwm_output_pin),
    .o_change (per_chg),
    .o_level  (per_lvl)
  );

  always @*
  begin
    pin_d = o_pwm_output_pin;
    // [RQ13] initial level at mode write
    if (we_pin && i_wr_data[`PSF_PIN_PWM])
    begin
      pin_d = init_lv;
    end
    // [RQ18] coincident matches hold level
    else if (duty_hit && period_hit)
    begin
      pin_d = o_pwm_output_pin;
    end
    else if (period_hit && per_chg)
    begin
      pin_d = per_lvl;
    end
    // [RQ10] low code on duty match
    else if (duty_hit && duty_chg)
    begin
      pin_d = duty_lvl;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  // [RQ12] period match raises event
  psf_irq u_irq
  (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_set       ({duty_hit, period_hit}),
    .i_clr_we    (we_status),
    .i_clr_data  (i_wr_data[1:0]),
    .i_mask_we   (we_mask),
    .i_mask_data (i_wr_data[1:0]),
    .o_status    (status),
    .o_mask      (mask),
    .o_irq       (o_irq)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (i_addr)
      `PSF_ADDR_CTRL:    rd_d = {24'h00_0000, ctrl_q};
      `PSF_ADDR_OLC:     rd_d = {24'h00_0000, olc_q};
      `PSF_ADDR_PERIOD:  rd_d = {16'h0000, period_compare_reg_q};
      `PSF_ADDR_DUTY:    rd_d = {16'h0000, duty_compare_reg_q};
      `PSF_ADDR_BUFFER:  rd_d = {16'h0000, duty_buffer_reg_q};
      `PSF_ADDR_COUNT:   rd_d = {16'h0000, up_counter_q};
      `PSF_ADDR_STATUS:  rd_d = {30'h0000_0000, status};
      `PSF_ADDR_MASK:    rd_d = {30'h0000_0000, mask};
      `PSF_ADDR_PINMODE: rd_d = {30'h0000_0000, o_pwm_output_pin,
                                 pwm_mode_q};
      default:           rd_d = 32'h0000_0000;
    endcase
    if (!i_rd_en)
    begin
      rd_d = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ctrl_q               <= `PSF_RST_CTRL;
      olc_q                <= `PSF_RST_OLC;
      period_compare_reg_q <= `PSF_RST_PERIOD;
      duty_compare_reg_q   <= `PSF_RST_DUTY;
      duty_buffer_reg_q    <= `PSF_RST_BUFFER;
      up_counter_q         <= `PSF_RST_COUNT;
      pre_q                <= {`PSF_PRE_W{1'b0}};
      pwm_mode_q           <= 1'b0;
      o_pwm_output_pin     <= 1'b0;
      o_pwm_oe_n           <= 1'b1;
      o_rd_data            <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q               <= ctrl_d;
      olc_q                <= olc_d;
      period_compare_reg_q <= period_compare_reg_d;
      duty_compare_reg_q   <= duty_compare_reg_d;
      duty_buffer_reg_q    <= duty_buffer_reg_d;
      up_counter_q         <= up_counter_d;
      pre_q                <= pre_d;
      pwm_mode_q           <= pwm_mode_d;
      o_pwm_output_pin     <= pin_d;
      // pin driven only in pwm mode
      o_pwm_oe_n           <= ~pwm_mode_d;
      o_rd_data            <= rd_d;
    end
  end

endmodule
`default_nettype wire

//--- verification/psf_sva.sv
// Purpose: port checker for the single-edge pwm channel
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows ctrl and mask writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module psf_sva
(
  input wire        i_clk_sys,
  input wire        i_sys_rst,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wr_data,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [31:0] o_rd_data,
  input wire        o_pwm_output_pin,
  input wire        o_pwm_oe_n,
  input wire        o_irq
);
  logic [7:0] ctrl_q;
  logic [1:0] mask_q;
  wire        wr_pm = i_wr_en && i_addr == `PSF_ADDR_PINMODE;
  wire        wr_mk = i_wr_en && i_addr == `PSF_ADDR_MASK;

  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ctrl_q <= `PSF_RST_CTRL;
      mask_q <= `PSF_RST_MASK;
    end
    else
    begin
      if (i_wr_en && i_addr == `PSF_ADDR_CTRL)
        ctrl_q <= i_wr_data[7:0];
      if (wr_mk)
        mask_q <= i_wr_data[1:0];
    end
  end

  // ----
  // assertions
  // ----
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 32'h0)
    else $error("read data not zero when idle");
  init_level_a: assert property (wr_pm && i_wr_data[0] |=>
    o_pwm_output_pin == ctrl_q[`PSF_CTRL_INIT] && !o_pwm_oe_n)
    else $error("pin not at initial level");
  oe_set_a: assert property (wr_pm |=>
    o_pwm_oe_n == !$past(i_wr_data[0]))
    else $error("enable does not follow mode");
  oe_hold_a: assert property (!wr_pm |=> $stable(o_pwm_oe_n))
    else $error("enable moved without mode write");
  stop_hold_a: assert property ((!ctrl_q[`PSF_CTRL_RUN] || o_pwm_oe_n)
    && !wr_pm |=> $stable(o_pwm_output_pin))
    else $error("pin moved while stopped");
  irq_mask_a: assert property ($rose(o_irq) |-> mask_q != 2'h0)
    else $error("interrupt with all masked");
  irq_off_a: assert property (wr_mk && i_wr_data[1:0] == 2'h0 ##1 !wr_mk
    |=> !o_irq)
    else $error("interrupt after masking");
  rd_pin_a: assert property (i_rd_en && i_addr == `PSF_ADDR_PINMODE |=>
    o_rd_data[1:0] == {$past(o_pwm_output_pin), !$past(o_pwm_oe_n)})
    else $error("pin mode readback wrong");

  cover property (o_irq);
  cover property ($rose(o_pwm_output_pin));
  cover property ($fell(o_pwm_output_pin));
endmodule

bind psf_top psf_sva i_psf_sva
(
  .i_clk_sys, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
  .o_rd_data, .o_pwm_output_pin, .o_pwm_oe_n, .o_irq
);
`default_nettype wire

//--- verification/psf_load.sv
// Purpose: load on the pwm pin, counts cycles seen high
// Assumes: pin has a pull-down when released
// Notes:   count cleared by the bench before each window
`timescale 1ns/1ps
`default_nettype none

module psf_load
(
  input  wire         i_clk_sys,
  input  wire         i_clr,
  input  wire         i_pin,
  input  wire         i_oe_n,
  output logic [15:0] o_high
);
  // released pin falls to the pull-down
  wire lvl = i_oe_n ? 1'b0 : i_pin;

  always @(posedge i_clk_sys)
  begin
    if (i_clr)
      o_high <= 16'h0;
    else
      o_high <= o_high + {15'h0, lvl};
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: self-checking bench for the pwm channel
// Assumes: prescale 1, period 7, so one period is 8 clocks
// Notes:   duty measured by the load over whole periods
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.vh"

module testbench;
  logic        clk, rst, we, re, clr, pin, oe_n, irq, rd_seen;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, d;
  logic [15:0] high;
  logic [63:0] q[$];
  logic [63:0] e;
  int          fail_count, checked, cyc;
  integer      seed;
  logic [7:0]  ra [10] = '{`PSF_ADDR_CTRL, `PSF_ADDR_OLC,
    `PSF_ADDR_PERIOD, `PSF_ADDR_DUTY, `PSF_ADDR_BUFFER, `PSF_ADDR_COUNT,
    `PSF_ADDR_STATUS, `PSF_ADDR_MASK, `PSF_ADDR_PINMODE, 8'h24};
  logic [31:0] rv [10] = '{{24'h0, `PSF_RST_CTRL}, {24'h0, `PSF_RST_OLC},
    {16'h0, `PSF_RST_PERIOD}, {16'h0, `PSF_RST_DUTY},
    {16'h0, `PSF_RST_BUFFER}, {16'h0, `PSF_RST_COUNT},
    {30'h0, `PSF_RST_STATUS}, {30'h0, `PSF_RST_MASK}, 32'h0, 32'h0};
  // olc, duty, high cycles in 4 periods (ffff: constant level)
  logic [31:0] tb [8] = '{32'h52030010, 32'h55000000, 32'h5200001c,
    32'h52090000, 32'h53030010, 32'h61030010, 32'h70090010, 32'h8403ffff};

  psf_top i_psf_top
  (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdat),
    .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdat),
    .o_pwm_output_pin(pin), .o_pwm_oe_n(oe_n), .o_irq(irq)
  );
  psf_load i_psf_load
  (
    .i_clk_sys(clk), .i_clr(clr), .i_pin(pin), .i_oe_n(oe_n), .o_high(high)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b0;
      clr <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    we <= 1'b1;
    re <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    we <= 1'b0;
    q.push_back({m, x});
  endtask

  task automatic meas(input int n, input logic [15:0] x);
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b0;
    clr <= 1'b1;
    tick(n + 1);
    #1;
    if (x === 16'hffff)
      check(high == 16'h0 || high == 16'd32, 1'b1);
    else
      check(high, x);
  endtask

  // clear old events first, so only a fresh period match ends the wait
  task automatic wait_irq;
    int n;
    n = 0;
    wr(`PSF_ADDR_STATUS, 32'h3);
    tick(2);
    while (irq !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check(irq, 1'b1);
  endtask

  // read results, one cycle after each read strobe
  always @(posedge clk)
  begin
    if (rd_seen === 1'b1)
    begin
      e = q.pop_front();
      check(rdat & e[63:32], e[31:0]);
    end
    rd_seen <= re;
    cyc <= cyc + 1;
    if (cyc > 5000)
    begin
      fail_count++;
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    clr = 1'b0;
    addr = 8'h0;
    wdat = 32'h0;
    rd_seen = 1'b0;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    seed = 32'h493cf668;
    tick(12);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(ra[i], 32'hffffffff, rv[i]);
    for (int i = 2; i < 5; i++)
    begin
      d = $random(seed);
      wr(ra[i], d);
      rd(ra[i], 32'hffffffff, {16'h0, d[15:0]});
    end
    wr(`PSF_ADDR_PERIOD, 32'h9c3f);
    rd(`PSF_ADDR_PERIOD, 32'hffffffff, 32'h9c3f);
    wr(`PSF_ADDR_PERIOD, 32'h7);
    wr(`PSF_ADDR_DUTY, 32'h9);
    wr(`PSF_ADDR_BUFFER, 32'h9);
    for (int i = 0; i < 2; i++)
    begin
      wr(`PSF_ADDR_CTRL, i << `PSF_CTRL_INIT);
      wr(`PSF_ADDR_PINMODE, 32'h1);
      rd(`PSF_ADDR_PINMODE, 32'h3, {30'h0, i[0], 1'b1});
      wr(`PSF_ADDR_PINMODE, 32'h0);
    end
    wr(`PSF_ADDR_CTRL, 32'h1);
    wr(`PSF_ADDR_PINMODE, 32'h1);
    tick(20);
    check(irq, 1'b0);
    rd(`PSF_ADDR_STATUS, 32'h1, 32'h1);
    wr(`PSF_ADDR_MASK, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(`PSF_ADDR_OLC, {24'h0, tb[i][31:24]});
      wr(`PSF_ADDR_DUTY, {24'h0, tb[i][23:16]});
      tick(16);
      meas(32, tb[i][15:0]);
      rd(`PSF_ADDR_COUNT, 32'hfffffff8, 32'h0);
    end
    wr(`PSF_ADDR_OLC, 32'h52);
    wr(`PSF_ADDR_DUTY, 32'h9);
    tick(16);
    wait_irq();
    rd(`PSF_ADDR_STATUS, 32'h1, 32'h1);
    wr(`PSF_ADDR_OLC, 32'h62);
    wait_irq();
    wr(`PSF_ADDR_DUTY, 32'h7);
    wr(`PSF_ADDR_BUFFER, 32'h7);
    wr(`PSF_ADDR_OLC, 32'h52);
    tick(8);
    meas(32, 16'd32);
    wr(`PSF_ADDR_CTRL, 32'h3);
    wr(`PSF_ADDR_BUFFER, 32'h9);
    meas(8, 16'd8);
    tick(8);
    meas(32, 16'd0);
    wr(`PSF_ADDR_DUTY, 32'h0);
    wr(`PSF_ADDR_BUFFER, 32'h3);
    // duty zero is replaced by the buffer at the next counter clear
    tick(1);
    rd(`PSF_ADDR_DUTY, 32'hffffffff, 32'h3);
    tick(16);
    meas(32, 16'd16);
    // masking all events drops the pending interrupt
    wr(`PSF_ADDR_MASK, 32'h0);
    tick(2);
    check(irq, 1'b0);
    tick(2);
    final_report();
  end
endmodule
`default_nettype wire
